// File: hdl/seqstat_params.svh
// constants for the target sequence status and synchronous offset block
// assumes inclusion by the design file only
`ifndef SEQSTAT_PARAMS_SVH
`define SEQSTAT_PARAMS_SVH
`define ADDR_FIFO_STEP    12'h01c
`define ADDR_CTRL         12'h020
`define ADDR_STATUS       12'h024
`define ADDR_CONFIG2      12'h028
`define CFG2_SCSI2_BIT    3
`define CTRL_TEST_BIT     0
`define CTRL_SOFTRST_BIT  1
`define OFFSET_RESET      4'h0
`define OFFSET_MAX        4'hf
`define OFFSET_MSB        3
`define FIFO_TEST_BIT     5
`define IRQ_DISC_BIT      5
`define IRQ_ATN_BIT       4
`define IRQ_SVC_BIT       3
`define IRQ_SEL_ATN_BIT   1
`define IRQ_SEL_BIT       0
`define STEP_0            3'h0
`define STEP_1            3'h1
`define STEP_2            3'h2
`define STEP_4            3'h4
`define STEP_5            3'h5
`define STEP_6            3'h6
`define MSG_BYTES_SCSI2   2'h3
`define FIFO_COUNT_W      5
`endif

// File: hdl/seqstat_pkg.sv
// types for the target sequence status and synchronous offset block
// assumes seqstat_params.svh for numeric constants
package seqstat_pkg;
	typedef enum logic [3:0] {
		SEL_ATN       = 4'h0,
		RECV_CMD      = 4'h1,
		DISCONNECT    = 4'h2,
		TERMINATE     = 4'h3,
		CMD_COMPLETE  = 4'h4
	} seq_kind_e;

	// what the sequencer saw when it stopped
	typedef struct packed {
		logic      parity_err;
		logic      invalid_id;
		logic      atn;
		logic [1:0] msg_bytes;
		logic      cmd_phase;
		logic      done;
	} seq_end_s;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_REPORT = 3'b010,
		ST_HOLD   = 3'b100
	} fsm_e;

	typedef struct packed {
		fsm_e       fsm;
		logic [2:0] step;
		logic [7:0] irq;
		logic       irq_valid;
		logic       bus_free;
		logic [3:0] offset;
		logic [3:0] outstanding;
		logic       test_mode;
		logic [7:0] config2;
		logic [7:0] rdata;
		logic       ack_out;
	} state_s;
endpackage

// File: hdl/seqstat_core.sv
// target sequence end reporting, fifo status read and synchronous offset
// assumes a single 125 MHz pclk; scsi-side inputs are already synchronised
// Notes on behaviour
// - scsi-2 select with atn, parity or bad identify on byte one: step 0, bit 1
// - scsi-2 select with atn, parity on byte two or three: step 4, bit 1
// - atn still high after third message byte: step 4, bits 4 and 1
// - parity in command phase after three bytes: step 5, bit 1, bit 4 if atn
// - three bytes and full command block received: step 6, bit 1 only
// - receive command parity error: step 1, bit 3, bit 4 if atn
// - receive command complete: step 2, bit 3, bit 4 if atn
// - disconnect with atn: step 0 or 1 by bytes sent, bits 4 and 3
// - disconnect complete: bus freed, step 2, bits 5 and 3
// - terminate or command complete with atn: step 0 or 1, bits 4 and 3
// - terminate complete: bus freed, step 2, bits 5 and 3
// - command complete done: step 2, bit 3 only, no disconnect
// - fifo status read returns byte count in low five bits
// - normal mode: top three bits of fifo status mirror sequence step
// - test mode: bit 5 shows outstanding count below the offset (room left to send)
// - offset low four bits: zero async, nonzero synchronous
// - nonzero offset caps outstanding unacknowledged synchronous bytes
// - sending pauses at offset, then one byte per acknowledge
// - receiving: one acknowledge per byte leaving fifo; offset max 15
// - hard and soft chip reset clear offset; scsi reset leaves it
// - config2 scsi-2 bit enables three-byte message exchange
// - scsi-2 clear, atn held after first byte: step 0, bits 4 and 1
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "seqstat_params.svh"
module seqstat_core
	import seqstat_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sequencer end report
	input  wire logic        seq_end_valid,
	input  wire seq_kind_e   seq_kind,
	input  wire seq_end_s    seq_end,
	input  wire logic        scsi_bus_reset,
	// fifo and data phase
	input  wire logic [4:0]  fifo_byte_count,
	input  wire logic        sync_byte_sent,
	input  wire logic        sync_ack_rcvd,
	input  wire logic        rx_fifo_pop,
	input  wire logic        sending,
	// results
	output logic [2:0]       seq_step,
	output logic [7:0]       irq_bits,
	output logic             irq_valid,
	output logic             bus_free,
	output logic             sync_mode,
	output logic             send_allowed,
	output logic             rx_ack,
	output logic             scsi2_enable
);
	state_s     q, d;
	logic       wr_en;
	logic       rd_en;
	logic       soft_rst;

	// interrupt byte from a list of bit flags; several bits can be set
	function automatic logic [7:0] irq_of(input logic disc, input logic atn,
		input logic svc, input logic sel_atn);
		logic [7:0] r;
		r = 8'h00;
		r[`IRQ_DISC_BIT]    = disc;
		r[`IRQ_ATN_BIT]     = atn;
		r[`IRQ_SVC_BIT]     = svc;
		r[`IRQ_SEL_ATN_BIT] = sel_atn;
		return r;
	endfunction

	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = psel && !penable && !pwrite;
	assign soft_rst = wr_en && (paddr == `ADDR_CTRL) && pwdata[`CTRL_SOFTRST_BIT];

	always_comb begin
		d = q;
		d.ack_out = 1'b0;
		if (soft_rst) begin
			d.offset      = `OFFSET_RESET;
			d.outstanding = 4'h0;
			d.test_mode   = 1'b0;
			d.config2     = 8'h00;
			d.step        = `STEP_0;
			d.irq         = 8'h00;
			d.irq_valid   = 1'b0;
			d.bus_free    = 1'b0;
			d.fsm         = ST_IDLE;
		end else begin
			// scsi bus reset intentionally leaves the offset alone
			if (scsi_bus_reset)
				d.bus_free = 1'b1;
			if (wr_en) begin
				unique case (paddr)
					`ADDR_FIFO_STEP: begin
						d.offset = pwdata[`OFFSET_MSB:0];
					end
					`ADDR_CTRL: begin
						// test mode is sticky until a chip reset
						d.test_mode = q.test_mode | pwdata[`CTRL_TEST_BIT];
					end
					`ADDR_CONFIG2: begin
						d.config2 = pwdata[7:0];
					end
					default: begin
					end
				endcase
			end
			// counter follows sends and acknowledges; both in one cycle cancel
			if (q.offset != `OFFSET_RESET && sending) begin
				if (sync_byte_sent && !sync_ack_rcvd && q.outstanding < q.offset)
					d.outstanding = q.outstanding + 4'h1;
				else if (!sync_byte_sent && sync_ack_rcvd && q.outstanding != 4'h0)
					d.outstanding = q.outstanding - 4'h1;
			end else begin
				d.outstanding = 4'h0;
			end
			// in synchronous mode the receiving side acknowledges each byte leaving the fifo
			if (q.offset != `OFFSET_RESET && !sending && rx_fifo_pop)
				d.ack_out = 1'b1;
			unique case (q.fsm)
				ST_IDLE: begin
					if (seq_end_valid)
						d.fsm = ST_REPORT;
				end
				ST_REPORT: d.fsm = ST_HOLD;
				ST_HOLD:   d.fsm = ST_IDLE;
				default:   d.fsm = ST_IDLE;
			endcase
			if (seq_end_valid) begin
				d.irq_valid = 1'b1;
				d.bus_free  = 1'b0;
				unique case (seq_kind)
					SEL_ATN: begin
						if (!q.config2[`CFG2_SCSI2_BIT]) begin
							d.step = `STEP_0;
							d.irq  = irq_of(1'b0, seq_end.atn, 1'b0, 1'b1);
						end else if (seq_end.msg_bytes <= 2'h1 &&
							(seq_end.parity_err || seq_end.invalid_id)) begin
							d.step = `STEP_0;
							d.irq  = irq_of(1'b0, 1'b0, 1'b0, 1'b1);
						end else if (!seq_end.cmd_phase && seq_end.parity_err) begin
							d.step = `STEP_4;
							d.irq  = irq_of(1'b0, 1'b0, 1'b0, 1'b1);
						end else if (!seq_end.cmd_phase) begin
							d.step = `STEP_4;
							d.irq  = irq_of(1'b0, 1'b1, 1'b0, 1'b1);
						end else if (seq_end.parity_err) begin
							d.step = `STEP_5;
							d.irq  = irq_of(1'b0, seq_end.atn, 1'b0, 1'b1);
						end else begin
							d.step = `STEP_6;
							d.irq  = irq_of(1'b0, 1'b0, 1'b0, 1'b1);
						end
					end
					RECV_CMD: begin
						d.step = seq_end.parity_err ? `STEP_1 : `STEP_2;
						d.irq  = irq_of(1'b0, seq_end.atn, 1'b1, 1'b0);
					end
					DISCONNECT, TERMINATE: begin
						if (seq_end.done) begin
							d.step     = `STEP_2;
							d.irq      = irq_of(1'b1, 1'b0, 1'b1, 1'b0);
							d.bus_free = 1'b1;
						end else begin
							d.step = (seq_end.msg_bytes >= 2'h2 && seq_kind == DISCONNECT) ||
								(seq_end.msg_bytes >= 2'h1 && seq_kind == TERMINATE) ?
								`STEP_1 : `STEP_0;
							d.irq  = irq_of(1'b0, 1'b1, 1'b1, 1'b0);
						end
					end
					CMD_COMPLETE: begin
						if (seq_end.done) begin
							d.step = `STEP_2;
							d.irq  = irq_of(1'b0, 1'b0, 1'b1, 1'b0);
						end else begin
							d.step = seq_end.msg_bytes >= 2'h1 ? `STEP_1 : `STEP_0;
							d.irq  = irq_of(1'b0, 1'b1, 1'b1, 1'b0);
						end
					end
					default: begin
					end
				endcase
			end
		end
		// read data captured in the setup cycle
		if (rd_en) begin
			unique case (paddr)
				`ADDR_FIFO_STEP: begin
					// count may be unstable mid transfer
					d.rdata = {q.step, fifo_byte_count};
					if (q.test_mode)
						d.rdata[`FIFO_TEST_BIT] = (q.outstanding != q.offset);
				end
				`ADDR_STATUS:  d.rdata = q.irq;
				`ADDR_CONFIG2: d.rdata = q.config2;
				`ADDR_CTRL:    d.rdata = {7'h00, q.test_mode};
				default:       d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.fsm         <= ST_IDLE;
			q.step        <= `STEP_0;
			q.irq         <= 8'h00;
			q.irq_valid   <= 1'b0;
			q.bus_free    <= 1'b0;
			q.offset      <= `OFFSET_RESET;
			q.outstanding <= 4'h0;
			q.test_mode   <= 1'b0;
			q.config2     <= 8'h00;
			q.rdata       <= 8'h00;
			q.ack_out     <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign prdata       = {24'h000000, q.rdata};
	assign pready       = 1'b1;
	assign pslverr      = 1'b0;
	assign seq_step     = q.step;
	assign irq_bits     = q.irq;
	assign irq_valid    = q.irq_valid;
	assign bus_free     = q.bus_free;
	assign sync_mode    = (q.offset != `OFFSET_RESET);
	// pause when outstanding reaches the offset
	assign send_allowed = !sync_mode || (q.outstanding < q.offset);
	assign rx_ack       = q.ack_out;
	assign scsi2_enable = q.config2[`CFG2_SCSI2_BIT];

	property p_offset_cap;
		@(posedge pclk) disable iff (!presetn)
		sync_mode |-> (q.outstanding <= q.offset);
	endproperty
	a_offset_cap: assert property (p_offset_cap) else $error("outstanding over offset");

	property p_disc_done;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == DISCONNECT && seq_end.done)
		|=> (seq_step == `STEP_2 && irq_bits == 8'h28 && bus_free);
	endproperty
	a_disc_done: assert property (p_disc_done) else $error("disconnect end wrong");

	property p_cc_done;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == CMD_COMPLETE && seq_end.done)
		|=> (seq_step == `STEP_2 && irq_bits == 8'h08 && !bus_free);
	endproperty
	a_cc_done: assert property (p_cc_done) else $error("command complete end wrong");

	property p_rx_ack;
		@(posedge pclk) disable iff (!presetn)
		(sync_mode && !sending && rx_fifo_pop && !soft_rst) |=> rx_ack;
	endproperty
	a_rx_ack: assert property (p_rx_ack) else $error("missing receive acknowledge");

	property p_soft_clear;
		@(posedge pclk) disable iff (!presetn)
		soft_rst |=> !sync_mode;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("offset not cleared");

	property p_async_zero;
		@(posedge pclk) disable iff (!presetn)
		!sync_mode |-> (send_allowed ##1 (q.outstanding == 4'h0));
	endproperty
	a_async_zero: assert property (p_async_zero) else $error("async transfer blocked");

	property p_sel_done;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && scsi2_enable &&
		 seq_end.cmd_phase && !seq_end.parity_err && seq_end.msg_bytes == 2'h3)
		|=> (seq_step == `STEP_6 && irq_bits == 8'h02);
	endproperty
	a_sel_done: assert property (p_sel_done) else $error("selection end wrong");

	property p_rcv_par;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == RECV_CMD && seq_end.parity_err)
		|=> (seq_step == `STEP_1 && irq_bits[`IRQ_SVC_BIT] && !irq_bits[`IRQ_SEL_ATN_BIT]);
	endproperty
	a_rcv_par: assert property (p_rcv_par) else $error("receive parity end wrong");

	// scsi-2 selection stops; the enable is the registered config2 copy
	property p_sel_first;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && scsi2_enable &&
		 seq_end.msg_bytes <= 2'h1 && (seq_end.parity_err || seq_end.invalid_id))
		|=> (seq_step == `STEP_0 && irq_bits == 8'h02);
	endproperty
	a_sel_first: assert property (p_sel_first) else $error("first byte stop wrong");

	property p_sel_msg_par;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && scsi2_enable &&
		 !seq_end.cmd_phase && seq_end.parity_err && seq_end.msg_bytes >= 2'h2)
		|=> (seq_step == `STEP_4 && irq_bits == 8'h02);
	endproperty
	a_sel_msg_par: assert property (p_sel_msg_par) else $error("msg parity stop wrong");

	property p_sel_atn_held;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && scsi2_enable &&
		 !seq_end.cmd_phase && !seq_end.parity_err && seq_end.atn &&
		 seq_end.msg_bytes == 2'h3)
		|=> (seq_step == `STEP_4 && irq_bits == 8'h12);
	endproperty
	a_sel_atn_held: assert property (p_sel_atn_held) else $error("atn held stop wrong");

	property p_sel_cmd_par;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && scsi2_enable &&
		 seq_end.cmd_phase && seq_end.parity_err && seq_end.msg_bytes == 2'h3)
		|=> (seq_step == `STEP_5 && irq_bits == {3'h0, $past(seq_end.atn), 4'h2});
	endproperty
	a_sel_cmd_par: assert property (p_sel_cmd_par) else $error("cmd parity stop wrong");

	property p_sel_one_byte;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == SEL_ATN && !scsi2_enable && seq_end.atn)
		|=> (seq_step == `STEP_0 && irq_bits == 8'h12);
	endproperty
	a_sel_one_byte: assert property (p_sel_one_byte) else $error("one byte stop wrong");

	property p_rcv_done;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == RECV_CMD && !seq_end.parity_err)
		|=> (seq_step == `STEP_2 && irq_bits == {3'h0, $past(seq_end.atn), 4'h8});
	endproperty
	a_rcv_done: assert property (p_rcv_done) else $error("receive complete wrong");

	// stopped by the partner's atn: the step tells how many bytes went out
	property p_disc_atn;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && seq_kind == DISCONNECT && !seq_end.done)
		|=> (irq_bits == 8'h18 &&
		     seq_step == ($past(seq_end.msg_bytes) >= 2'h2 ? `STEP_1 : `STEP_0));
	endproperty
	a_disc_atn: assert property (p_disc_atn) else $error("disconnect atn stop wrong");

	property p_term_atn;
		@(posedge pclk) disable iff (!presetn)
		(seq_end_valid && !soft_rst && !seq_end.done &&
		 (seq_kind == TERMINATE || seq_kind == CMD_COMPLETE))
		|=> (irq_bits == 8'h18 &&
		     seq_step == ($past(seq_end.msg_bytes) >= 2'h1 ? `STEP_1 : `STEP_0));
	endproperty
	a_term_atn: assert property (p_term_atn) else $error("status atn stop wrong");

	// an acknowledge with no byte sent in the same cycle always frees room for at least one more byte
	property p_ack_resume;
		@(posedge pclk) disable iff (!presetn)
		(sync_mode && sending && sync_ack_rcvd && !sync_byte_sent && !wr_en && !soft_rst)
		|=> send_allowed;
	endproperty
	a_ack_resume: assert property (p_ack_resume) else $error("no send after ack");

	property p_count_up;
		@(posedge pclk) disable iff (!presetn)
		(sync_mode && sending && send_allowed && sync_byte_sent && !sync_ack_rcvd &&
		 !wr_en && !soft_rst)
		|=> (q.outstanding == $past(q.outstanding) + 4'h1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("byte not counted");

	property p_fifo_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == `ADDR_FIFO_STEP && !q.test_mode)
		|=> (prdata[7:0] == {$past(seq_step), $past(fifo_byte_count)});
	endproperty
	a_fifo_read: assert property (p_fifo_read) else $error("fifo status read wrong");

	// the test flag is room left to send, not the raw count
	property p_test_flag;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == `ADDR_FIFO_STEP && q.test_mode)
		|=> (prdata[`FIFO_TEST_BIT] == $past(sync_mode && send_allowed));
	endproperty
	a_test_flag: assert property (p_test_flag) else $error("test flag wrong");
endmodule // seqstat_core

// File: testbench/seqstat_peer.sv
// far-end model: remote scsi device acknowledging synchronous bytes
// assumes one pulse on byte_sent per byte; hold stalls acknowledges
`timescale 1ns/1ps
module seqstat_peer (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// data phase
	input  wire logic byte_sent,
	input  wire logic hold,
	output logic      ack
);
	logic [4:0] pending_q;
	logic       give;
	// at most one ack every other cycle, so a slow partner is the norm
	assign give = !hold && !ack && (pending_q != 5'h00);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_q <= 5'h00;
			ack       <= 1'b0;
		end else begin
			ack       <= give; // one ack per byte received
			pending_q <= pending_q + {4'h0, byte_sent} - {4'h0, give};
		end
	end
endmodule // seqstat_peer

// File: testbench/scsi_target_status_and_sync_offset_tb_top.sv
// bench for seqstat_core: sequence report table, fifo status, offset throttle
// assumes an apb slave answering through pready and seqstat_peer as far side
`timescale 1ns/1ps
module scsi_target_status_and_sync_offset_tb_top;
	import seqstat_pkg::*;
	typedef struct {
		seq_kind_e k; seq_end_s e; logic s2; logic [2:0] st; logic [7:0] irq; logic bf;
	} row_s;
	row_s rows [21] = '{
		'{CMD_COMPLETE, 7'h01, 1'b0, 3'h2, 8'h08, 1'b0},
		'{SEL_ATN, 7'h44, 1'b1, 3'h0, 8'h02, 1'b0},
		'{SEL_ATN, 7'h24, 1'b1, 3'h0, 8'h02, 1'b0},
		'{SEL_ATN, 7'h48, 1'b1, 3'h4, 8'h02, 1'b0},
		'{SEL_ATN, 7'h1c, 1'b1, 3'h4, 8'h12, 1'b0},
		'{SEL_ATN, 7'h4e, 1'b1, 3'h5, 8'h02, 1'b0},
		'{SEL_ATN, 7'h5e, 1'b1, 3'h5, 8'h12, 1'b0},
		'{SEL_ATN, 7'h0f, 1'b1, 3'h6, 8'h02, 1'b0},
		'{SEL_ATN, 7'h14, 1'b0, 3'h0, 8'h12, 1'b0},
		'{RECV_CMD, 7'h40, 1'b0, 3'h1, 8'h08, 1'b0},
		'{RECV_CMD, 7'h50, 1'b0, 3'h1, 8'h18, 1'b0},
		'{RECV_CMD, 7'h01, 1'b0, 3'h2, 8'h08, 1'b0},
		'{RECV_CMD, 7'h11, 1'b0, 3'h2, 8'h18, 1'b0},
		'{DISCONNECT, 7'h14, 1'b0, 3'h0, 8'h18, 1'b0},
		'{DISCONNECT, 7'h18, 1'b0, 3'h1, 8'h18, 1'b0},
		'{TERMINATE, 7'h10, 1'b0, 3'h0, 8'h18, 1'b0},
		'{TERMINATE, 7'h14, 1'b0, 3'h1, 8'h18, 1'b0},
		'{CMD_COMPLETE, 7'h10, 1'b0, 3'h0, 8'h18, 1'b0},
		'{CMD_COMPLETE, 7'h14, 1'b0, 3'h1, 8'h18, 1'b0},
		'{DISCONNECT, 7'h01, 1'b0, 3'h2, 8'h28, 1'b1},
		'{TERMINATE, 7'h01, 1'b0, 3'h2, 8'h28, 1'b1}
	};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        seq_end_valid, scsi_bus_reset, sync_byte_sent, sync_ack_rcvd;
	seq_kind_e   seq_kind;
	seq_end_s    seq_end;
	logic [4:0]  fifo_byte_count;
	logic        rx_fifo_pop, sending, irq_valid, bus_free, sync_mode;
	logic        send_allowed, rx_ack, scsi2_enable, hold;
	logic [2:0]  seq_step;
	logic [7:0]  irq_bits;
	int          fails, total_checks, n;

	seqstat_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .seq_end_valid(seq_end_valid), .seq_kind(seq_kind),
		.seq_end(seq_end), .scsi_bus_reset(scsi_bus_reset), .fifo_byte_count(fifo_byte_count),
		.sync_byte_sent(sync_byte_sent), .sync_ack_rcvd(sync_ack_rcvd),
		.rx_fifo_pop(rx_fifo_pop), .sending(sending), .seq_step(seq_step),
		.irq_bits(irq_bits), .irq_valid(irq_valid), .bus_free(bus_free),
		.sync_mode(sync_mode), .send_allowed(send_allowed), .rx_ack(rx_ack),
		.scsi2_enable(scsi2_enable));
	seqstat_peer peer (.pclk(pclk), .presetn(presetn), .byte_sent(sync_byte_sent),
		.hold(hold), .ack(sync_ack_rcvd));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// caller sits just after an edge; an idle edge follows so psel never re-rises at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: a slave that never answers is caught by the watchdog
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		chk(pslverr, 1'b0, "slave error");
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask

	// one-cycle byte pulses; room is looked at on the falling edge, once settled
	task automatic burst();
		n = 0;
		@(negedge pclk);
		while (send_allowed === 1'b1 && n < 20) begin
			@(posedge pclk);
			sync_byte_sent <= 1'b1;
			@(posedge pclk);
			sync_byte_sent <= 1'b0;
			n++;
			@(negedge pclk);
		end
		@(posedge pclk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#300000 fails++;
		summarize();
	end

	initial begin
		{presetn, psel, penable, pwrite, seq_end_valid, scsi_bus_reset} = 6'h00;
		{sync_byte_sent, rx_fifo_pop} = 2'h0; sending = 1'b1; hold = 1'b1;
		paddr = 12'h000; pwdata = 32'h0; seq_kind = SEL_ATN; seq_end = '0;
		fifo_byte_count = 5'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(sync_mode, 1'b0, "offset after reset");
		foreach (rows[i]) begin
			apb(1'b1, 12'h020, 32'h2);
			apb(1'b1, 12'h028, {28'h0, rows[i].s2, 3'h0});
			chk(scsi2_enable, rows[i].s2, "scsi2 enable");
			apb(1'b0, 12'h028, 32'h0);
			chk(q, {28'h0, rows[i].s2, 3'h0}, "config2 read");
			seq_kind <= rows[i].k; seq_end <= rows[i].e; seq_end_valid <= 1'b1;
			fifo_byte_count <= 5'(i);
			@(posedge pclk);
			seq_end_valid <= 1'b0;
			@(posedge pclk);
			chk({seq_step, irq_bits, irq_valid, bus_free},
				{rows[i].st, rows[i].irq, 1'b1, rows[i].bf}, "sequence end");
			apb(1'b0, 12'h01c, 32'h0);
			chk(q, {24'h0, rows[i].st, 5'(i)}, "fifo status");
			apb(1'b0, 12'h024, 32'h0);
			chk(q[7:0], rows[i].irq, "irq read");
		end
		apb(1'b1, 12'h0f0, 32'h5a);
		apb(1'b0, 12'h0f0, 32'h0);
		chk(q, 32'h0, "unmapped read");
		apb(1'b1, 12'h01c, 32'h10);
		chk(sync_mode, 1'b0, "low four bits zero");
		apb(1'b1, 12'h01c, 32'hf);
		chk(sync_mode, 1'b1, "offset max");
		apb(1'b1, 12'h01c, 32'h3);
		apb(1'b1, 12'h020, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk(q, 32'h1, "test mode read");
		burst();
		chk(n, 3, "bytes before pause");
		apb(1'b0, 12'h01c, 32'h0);
		chk(q[5], 1'b0, "offset expired flag");
		hold <= 1'b0;
		@(posedge pclk);
		hold <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h01c, 32'h0);
		chk(q[5], 1'b1, "offset available flag");
		burst();
		chk(n, 1, "one byte per ack");
		hold <= 1'b0;
		sending <= 1'b0;
		rx_fifo_pop <= 1'b1;
		@(posedge pclk);
		rx_fifo_pop <= 1'b0;
		@(posedge pclk);
		chk(rx_ack, 1'b1, "receive ack");
		@(posedge pclk);
		chk(rx_ack, 1'b0, "receive ack single");
		scsi_bus_reset <= 1'b1;
		repeat (2) @(posedge pclk);
		scsi_bus_reset <= 1'b0;
		chk({sync_mode, bus_free}, 2'h3, "scsi reset keeps offset");
		apb(1'b1, 12'h020, 32'h2);
		chk(sync_mode, 1'b0, "soft reset offset");
		apb(1'b1, 12'h01c, 32'h5);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({sync_mode, send_allowed}, 2'h1, "hard reset offset");
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({sync_mode, irq_valid, bus_free, seq_step}, 6'h00, "state after reset");
		summarize();
	end
endmodule // scsi_target_status_and_sync_offset_tb_top
